// ---- verilog/slope_adc_pkg.sv ----
package slope_adc_pkg;

    // register addresses on the plain register port
    localparam logic [3:0] ADDR_TIMER_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_TIMER_FLAGS   = 4'h1;
    localparam logic [3:0] ADDR_CAPTURE_HIGH  = 4'h2;
    localparam logic [3:0] ADDR_CAPTURE_LOW   = 4'h3;
    localparam logic [3:0] ADDR_COMPARE_HIGH  = 4'h4;
    localparam logic [3:0] ADDR_COMPARE_LOW   = 4'h5;
    localparam logic [3:0] ADDR_COUNT_HIGH    = 4'h6;
    localparam logic [3:0] ADDR_COUNT_LOW     = 4'h7;
    localparam logic [3:0] ADDR_ANALOG_CTRL   = 4'h8;
    localparam logic [3:0] ADDR_CHANNEL_SEL   = 4'h9;
    localparam logic [3:0] ADDR_IRQ_STATUS    = 4'ha;
    localparam logic [3:0] ADDR_IRQ_MASK      = 4'hb;

    // timer control bit positions
    localparam int CTL_CAPTURE_SOURCE_ON = 0;
    localparam int CTL_CAPTURE_IRQ_EN    = 1;
    localparam int CTL_CAPTURE_EDGE      = 2;
    localparam int CTL_COMPARE_IRQ_EN    = 3;
    localparam int CTL_WRAP_IRQ_EN       = 4;

    // timer flags bit positions
    localparam int FLG_CAPTURE = 7;
    localparam int FLG_COMPARE = 6;
    localparam int FLG_WRAP    = 5;

    // analog control bit positions
    localparam int ANA_CURRENT_ON     = 0;
    localparam int ANA_COMP1_ON       = 1;
    localparam int ANA_COMP2_ON       = 2;
    localparam int ANA_POLARITY_SWAP  = 3;
    localparam int ANA_OFFSET_SELECT  = 4;
    localparam int ANA_COMP1_PIN_OUT  = 5;

    // channel select bit positions
    localparam int CHN_SAMPLE_KEEP   = 6;
    localparam int CHN_DIRECT_KEEP   = 7;

    // interrupt status bit positions
    localparam int IRQ_CAPTURE  = 0;
    localparam int IRQ_COMPARE  = 1;
    localparam int IRQ_WRAP     = 2;
    localparam int IRQ_CHAN_ERR = 3;

    // reset values
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    localparam logic [15:0] RESET_COMPARE  = 16'hffff;
    localparam logic [15:0] RESET_COUNT    = 16'h0000;

    // register request from the cpu side, plain register port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // analog drive outputs
    typedef struct packed {
        logic       bias_on;
        logic       current_on;
        logic       comp1_on;
        logic       comp2_on;
        logic       polarity_swap;
        logic       offset_select;
        logic       comp1_pin_out;
        logic [7:0] channel_select;
        logic       discharge;
    } analog_drive_t;

endpackage : slope_adc_pkg

// ---- verilog/sync_two_ff.sv ----
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_ref_clk,  // system clock
    input  wire logic             i_reset,    // synchronous reset, active high
    input  wire logic [WIDTH-1:0] i_async,    // asynchronous level
    output logic      [WIDTH-1:0] o_sync      // level in the clock domain
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // first stage feeds only the second stage
    always_comb begin
        state_next.first  = i_async;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_sync = state_reg.second;
endmodule // sync_two_ff
`default_nettype wire

// ---- verilog/slope_adc_timer_control.sv ----
// How it works
// - a read of the compare high byte blocks compare matches until the compare low byte is read.
// - changing capture enable, capture irq enable or edge select mid-ramp may set the capture flag; here such changes set no flag.
// - a flag clears only after a flags read and then a read of its own low-byte register.
// - while the capture flag is set it overrides compare and wrap flags.
// - clearing the capture flag with compare or wrap still set restarts a charge at once.
// - analog bias is on whenever current source, comparator 1 or comparator 2 is on.
// - offset select and comparator 1 pin output work only with the feature option set.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module slope_adc_timer_control #(
    parameter int COUNT_WIDTH = 16
) (
    input  wire logic                  i_ref_clk,         // 10 mhz system clock
    input  wire logic                  i_reset,           // synchronous reset, active high
    input  wire logic [3:0]            i_addr,            // register address
    input  wire logic [7:0]            i_wdata,           // write data
    input  wire logic                  i_wr,              // write strobe
    input  wire logic                  i_rd,              // read strobe
    input  wire logic                  i_comparator2_out, // comparator 2 pin level, async
    input  wire logic                  i_extra_feature_select, // feature option strap
    output logic [7:0]                 o_rdata,           // read data, cycle after strobe
    output logic                       o_irq,             // level interrupt
    output slope_adc_pkg::analog_drive_t o_analog         // analog control outputs
);
    import slope_adc_pkg::*;

    // registers split into two bytes, so only a 16 bit counter is served
    if (COUNT_WIDTH != 16) begin : g_width_check
        $error("COUNT_WIDTH must be 16");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] compare;
        logic [15:0] capture;
        logic [7:0]  compare_low_latch;
        logic [7:0]  count_low_latch;
        logic [7:0]  capture_low_latch;
        logic        compare_hold;      // compare high byte read, low pending
        logic        count_hold;
        logic        capture_hold;
        logic        capture_flag;
        logic        compare_match_flag;
        logic        counter_wrap_flag;
        logic [2:0]  flags_armed;       // flags seen set by a flags read
        logic [4:0]  timer_ctrl;
        logic [5:0]  analog_ctrl;
        logic [7:0]  channel_select_reg;
        logic [3:0]  irq_status;
        logic [3:0]  irq_mask;
        logic        cmp_prev;
        logic        discharge;
        logic        feature_latched;
        logic [7:0]  rdata;
        logic        irq;
        analog_drive_t analog;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic   cmp_sync;
    logic   feat_sync;

    // comparator 2 and the feature strap both arrive from pins
    sync_two_ff #(
        .WIDTH (2)
    ) u_cmp_sync (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_async   ({i_extra_feature_select, i_comparator2_out}),
        .o_sync    ({feat_sync, cmp_sync})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic is_addr(input reg_req_t r, input logic [3:0] a);
        return r.addr == a;
    endfunction

    reg_req_t req;
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic capture_edge;
        logic compare_event;
        logic wrap_event;
        logic cap_clear;
        logic cmp_clear;
        logic wrap_clear;
        logic [3:0] flag_vec;
        logic chan_err;
        logic keep_now;

        state_next    = state_reg;
        capture_edge  = 1'b0;
        compare_event = 1'b0;
        wrap_event    = 1'b0;
        cap_clear     = 1'b0;
        cmp_clear     = 1'b0;
        wrap_clear    = 1'b0;
        flag_vec      = 4'h0;
        chan_err      = 1'b0;
        keep_now      = 1'b0;

        // free running counter
        state_next.count = state_reg.count + 16'h0001;
        wrap_event = (state_reg.count == 16'hffff);
        // matches held off while a compare high read is pending
        compare_event = (state_reg.count == state_reg.compare) && !state_reg.compare_hold;

        // capture on the selected edge of comparator 2; the previous level is tracked even with
        // capture off, so control changes mid-ramp set no flag by themselves
        state_next.cmp_prev = cmp_sync;
        if (state_reg.timer_ctrl[CTL_CAPTURE_SOURCE_ON]) begin
            capture_edge = state_reg.timer_ctrl[CTL_CAPTURE_EDGE]
                         ? (cmp_sync && !state_reg.cmp_prev)
                         : (!cmp_sync && state_reg.cmp_prev);
        end

        // flags read arms a clear; the low-byte read completes it
        if (req.rd && is_addr(req, ADDR_TIMER_FLAGS)) begin
            state_next.flags_armed = {state_reg.capture_flag,
                                      state_reg.compare_match_flag,
                                      state_reg.counter_wrap_flag};
        end
        if (req.rd && is_addr(req, ADDR_CAPTURE_LOW)) begin
            cap_clear = state_reg.flags_armed[2];
            state_next.flags_armed[2] = 1'b0;
        end
        if (req.rd && is_addr(req, ADDR_COMPARE_LOW)) begin
            cmp_clear = state_reg.flags_armed[1];
            state_next.flags_armed[1] = 1'b0;
        end
        if (req.rd && is_addr(req, ADDR_COUNT_LOW)) begin
            wrap_clear = state_reg.flags_armed[0];
            state_next.flags_armed[0] = 1'b0;
        end

        // set wins over clear
        state_next.capture_flag       = capture_edge || (state_reg.capture_flag && !cap_clear);
        state_next.compare_match_flag = compare_event ||
                                        (state_reg.compare_match_flag && !cmp_clear);
        state_next.counter_wrap_flag  = wrap_event ||
                                        (state_reg.counter_wrap_flag && !wrap_clear);
        if (capture_edge) begin
            state_next.capture = state_reg.count;
        end

        // capacitor is discharged (ramp stopped) only while the capture flag stands; the capture
        // flag dominates, and once it drops with others still set the ramp resumes
        // at once, which is why software clears compare and wrap first
        if (state_reg.capture_flag) begin
            state_next.discharge = 1'b1;
        end else if (state_reg.compare_match_flag || state_reg.counter_wrap_flag) begin
            state_next.discharge = 1'b0;
        end else begin
            state_next.discharge = 1'b0;
        end

        // sticky interrupt status; capture precedence masks the other events
        flag_vec[IRQ_CAPTURE] = capture_edge;
        flag_vec[IRQ_COMPARE] = compare_event && !state_reg.capture_flag;
        flag_vec[IRQ_WRAP]    = wrap_event && !state_reg.capture_flag;

        // writes
        if (req.wr) begin
            unique case (req.addr)
                ADDR_TIMER_CTRL:   state_next.timer_ctrl = req.wdata[4:0];
                ADDR_COMPARE_HIGH: state_next.compare[15:8] = req.wdata;
                ADDR_COMPARE_LOW:  state_next.compare[7:0] = req.wdata;
                ADDR_ANALOG_CTRL:  state_next.analog_ctrl = req.wdata[5:0];
                ADDR_CHANNEL_SEL: begin
                    // channel change with a keep still on is flagged, not blocked
                    keep_now = state_reg.channel_select_reg[CHN_SAMPLE_KEEP] ||
                               state_reg.channel_select_reg[CHN_DIRECT_KEEP];
                    chan_err = keep_now &&
                               (req.wdata[5:0] != state_reg.channel_select_reg[5:0]);
                    state_next.channel_select_reg = req.wdata;
                end
                ADDR_IRQ_MASK:     state_next.irq_mask = req.wdata[3:0];
                default: ;
            endcase
        end
        flag_vec[IRQ_CHAN_ERR] = chan_err;

        // write one to clear, set wins
        if (req.wr && is_addr(req, ADDR_IRQ_STATUS)) begin
            state_next.irq_status = (state_reg.irq_status & ~req.wdata[3:0]) | flag_vec;
        end else begin
            state_next.irq_status = state_reg.irq_status | flag_vec;
        end
        // the enables in timer control also gate their events onto the line
        state_next.irq = |(state_reg.irq_status & state_reg.irq_mask &
                           {1'b1, state_reg.timer_ctrl[CTL_WRAP_IRQ_EN],
                            state_reg.timer_ctrl[CTL_COMPARE_IRQ_EN],
                            state_reg.timer_ctrl[CTL_CAPTURE_IRQ_EN]});

        // reads: capture and count high bytes latch the low byte so the pair is coherent
        state_next.rdata = RESET_BYTE;
        if (req.rd) begin
            unique case (req.addr)
                ADDR_TIMER_CTRL:   state_next.rdata = {3'b000, state_reg.timer_ctrl};
                ADDR_TIMER_FLAGS:  state_next.rdata = {state_reg.capture_flag,
                                                       state_reg.compare_match_flag,
                                                       state_reg.counter_wrap_flag, 5'b00000};
                ADDR_CAPTURE_HIGH: begin
                    state_next.rdata = state_reg.capture[15:8];
                    state_next.capture_low_latch = state_reg.capture[7:0];
                    state_next.capture_hold = 1'b1;
                end
                ADDR_CAPTURE_LOW: begin
                    state_next.rdata = state_reg.capture_hold ? state_reg.capture_low_latch
                                                              : state_reg.capture[7:0];
                    state_next.capture_hold = 1'b0;
                end
                ADDR_COMPARE_HIGH: begin
                    state_next.rdata = state_reg.compare[15:8];
                    state_next.compare_hold = 1'b1;
                end
                ADDR_COMPARE_LOW: begin
                    state_next.rdata = state_reg.compare[7:0];
                    state_next.compare_hold = 1'b0;
                end
                ADDR_COUNT_HIGH: begin
                    state_next.rdata = state_reg.count[15:8];
                    state_next.count_low_latch = state_reg.count[7:0];
                    state_next.count_hold = 1'b1;
                end
                ADDR_COUNT_LOW: begin
                    state_next.rdata = state_reg.count_hold ? state_reg.count_low_latch
                                                            : state_reg.count[7:0];
                    state_next.count_hold = 1'b0;
                end
                ADDR_ANALOG_CTRL:  state_next.rdata = {2'b00, state_reg.analog_ctrl};
                ADDR_CHANNEL_SEL:  state_next.rdata = state_reg.channel_select_reg;
                ADDR_IRQ_STATUS:   state_next.rdata = {4'h0, state_reg.irq_status};
                ADDR_IRQ_MASK:     state_next.rdata = {4'h0, state_reg.irq_mask};
                default:           state_next.rdata = RESET_BYTE;
            endcase
        end

        // strap already passed two flops; one more stage keeps the gate registered
        state_next.feature_latched = feat_sync;

        // analog drives
        state_next.analog.current_on    = state_reg.analog_ctrl[ANA_CURRENT_ON];
        state_next.analog.comp1_on      = state_reg.analog_ctrl[ANA_COMP1_ON];
        state_next.analog.comp2_on      = state_reg.analog_ctrl[ANA_COMP2_ON];
        state_next.analog.bias_on       = state_reg.analog_ctrl[ANA_CURRENT_ON] ||
                                          state_reg.analog_ctrl[ANA_COMP1_ON] ||
                                          state_reg.analog_ctrl[ANA_COMP2_ON];
        state_next.analog.polarity_swap = state_reg.analog_ctrl[ANA_POLARITY_SWAP];
        state_next.analog.offset_select = state_reg.analog_ctrl[ANA_OFFSET_SELECT] &&
                                          state_reg.feature_latched;
        state_next.analog.comp1_pin_out = state_reg.analog_ctrl[ANA_COMP1_PIN_OUT] &&
                                          state_reg.feature_latched;
        state_next.analog.channel_select = state_reg.channel_select_reg;
        state_next.analog.discharge     = state_reg.discharge;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_reg         <= '0;
            state_reg.compare <= RESET_COMPARE;
            state_reg.count   <= RESET_COUNT;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rdata  = state_reg.rdata;
    assign o_irq    = state_reg.irq;
    assign o_analog = state_reg.analog;
endmodule // slope_adc_timer_control
`default_nettype wire

// ---- bench/slope_adc_timer_control_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module slope_adc_timer_control_asserts
    import slope_adc_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic                         i_ref_clk,              // system clock
    input wire logic                         i_reset,                // synchronous reset
    input wire logic [3:0]                   i_addr,                 // register address
    input wire logic [7:0]                   i_wdata,                // write data
    input wire logic                         i_wr,                   // write strobe
    input wire logic                         i_rd,                   // read strobe
    input wire logic                         i_comparator2_out,      // comparator 2 level
    input wire logic                         i_extra_feature_select, // feature strap
    input wire logic [7:0]                   o_rdata,                // read data
    input wire logic                         o_irq,                  // level interrupt
    input wire slope_adc_pkg::analog_drive_t o_analog                // analog outputs
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////////////////////
    // helper state seen from the port only; forgetting a flag early is safe
    logic flags_rd_q;
    logic cap_seen;
    logic mask_zero;
    logic any_on;
    assign any_on = o_analog.current_on | o_analog.comp1_on | o_analog.comp2_on;
    always_ff @(posedge i_ref_clk) begin
        flags_rd_q <= i_rd && (i_addr == ADDR_TIMER_FLAGS);
        if (i_reset || (i_rd && i_addr == ADDR_CAPTURE_LOW)) begin
            cap_seen <= 1'b0;
        end else if (flags_rd_q && o_rdata[FLG_CAPTURE]) begin
            cap_seen <= 1'b1;
        end
        if (i_reset) begin
            mask_zero <= 1'b1;
        end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
            mask_zero <= (i_wdata == 8'h00);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // read data stand only in the cycle after a read strobe
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    bias_follows_a: assert property (any_on && $past(any_on) |-> o_analog.bias_on)
        else $error("bias off while an analog source is on");
    bias_drops_a: assert property (!any_on && !$past(any_on) |-> !o_analog.bias_on)
        else $error("bias on with no analog source on");
    offset_gated_a: assert property (!i_extra_feature_select && !$past(i_extra_feature_select)
        && !$past(i_extra_feature_select, 2) && !$past(i_extra_feature_select, 3)
        && !$past(i_extra_feature_select, 4) |-> !o_analog.offset_select)
        else $error("offset select active without feature option");
    pin_out_gated_a: assert property (!i_extra_feature_select [*5]
        |-> !o_analog.comp1_pin_out)
        else $error("comparator 1 pin output active without feature option");
    capture_sticky_a: assert property (flags_rd_q && cap_seen |-> o_rdata[FLG_CAPTURE])
        else $error("capture flag cleared without low byte read");
    discharge_hold_a: assert property (cap_seen |-> o_analog.discharge)
        else $error("discharge released while capture flag set");
    irq_masked_a: assert property (mask_zero && $past(mask_zero) && $past(mask_zero, 2)
        |-> !o_irq)
        else $error("interrupt raised with empty mask");
    // main scenarios
    capture_seen_c: cover property (cap_seen);
    compare_seen_c: cover property (flags_rd_q && o_rdata[FLG_COMPARE]);
    irq_high_c: cover property (o_irq);
endmodule // slope_adc_timer_control_asserts

bind slope_adc_timer_control slope_adc_timer_control_asserts #(
    .COUNT_WIDTH(COUNT_WIDTH)
) u_chk (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_comparator2_out(i_comparator2_out),
    .i_extra_feature_select(i_extra_feature_select), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_analog(o_analog)
);
`default_nettype wire

// ---- bench/slope_adc_timer_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module slope_adc_timer_control_test;
    import slope_adc_pkg::*;
    logic          i_ref_clk = 1'b0;
    logic          i_reset = 1'b1;
    logic [3:0]    i_addr = 4'h0;
    logic [7:0]    i_wdata = 8'h00;
    logic          i_wr = 1'b0;
    logic          i_rd = 1'b0;
    logic          i_comparator2_out = 1'b0;
    logic          i_extra_feature_select = 1'b0;
    logic [7:0]    o_rdata;
    logic          o_irq;
    analog_drive_t o_analog;
    int            error_cnt = 0;
    int            samples_checked = 0;
    logic [7:0]    d;
    logic [15:0]   cnt;
    always #50 i_ref_clk = ~i_ref_clk;
    slope_adc_timer_control #(.COUNT_WIDTH(16)) dut (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_comparator2_out(i_comparator2_out),
        .i_extra_feature_select(i_extra_feature_select), .o_rdata(o_rdata),
        .o_irq(o_irq), .o_analog(o_analog)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // register port tasks; strobes last one cycle, data sampled once settled
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #10 v = o_rdata;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (5) @(posedge i_ref_clk);
        #10;
    endtask
    // bounded poll of one flag bit; running out ends the run
    task automatic poll(input logic [3:0] a, input int b);
        logic [7:0] v;
        int         n;
        for (n = 0; n < 40; n++) begin
            rd(a, v);
            if (v[b] === 1'b1) begin
                return;
            end
        end
        $display("wrong value poll bit %0d expected 1 seen 0", b);
        error_cnt++;
        conclude();
    endtask
    // aim the compare a fixed distance ahead of the free running counter
    task automatic aim(input logic [15:0] ahead);
        logic [7:0] h;
        logic [7:0] l;
        logic [15:0] t;
        rd(ADDR_COUNT_HIGH, h);
        rd(ADDR_COUNT_LOW, l);
        t = {h, l} + ahead;
        wr(ADDR_COMPARE_HIGH, t[15:8]);
        wr(ADDR_COMPARE_LOW, t[7:0]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        rd(ADDR_COMPARE_HIGH, d);
        chk("compare high reset", 16'(RESET_COMPARE[15:8]), 16'(d));
        rd(ADDR_COMPARE_LOW, d);
        chk("compare low reset", 16'(RESET_COMPARE[7:0]), 16'(d));
        // unmapped place reads zero and ignores writes
        wr(4'hc, 8'h5a);
        rd(4'hc, d);
        chk("unmapped read", 16'h0000, 16'(d));
        // each analog source alone powers the bias
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_ANALOG_CTRL, (i == 0) ? 8'h00 : 8'(1 << (i - 1)));
            settle();
            chk("bias_on", 16'(i != 0), 16'(o_analog.bias_on));
        end
        // offset and pin output follow the feature strap
        wr(ADDR_ANALOG_CTRL, 8'h30);
        for (int i = 0; i < 3; i++) begin
            i_extra_feature_select <= (i == 1);
            settle();
            chk("offset_select", 16'(i == 1), 16'(o_analog.offset_select));
            chk("comp1_pin_out", 16'(i == 1), 16'(o_analog.comp1_pin_out));
        end
        // capture on a rising comparator edge; low byte read alone keeps the flag
        wr(ADDR_ANALOG_CTRL, 8'h04);
        wr(ADDR_TIMER_CTRL, 8'h05);
        i_comparator2_out <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        rd(ADDR_CAPTURE_LOW, d);
        poll(ADDR_TIMER_FLAGS, FLG_CAPTURE);
        chk("discharge", 16'h0001, 16'(o_analog.discharge));
        rd(ADDR_CAPTURE_LOW, d);
        rd(ADDR_TIMER_FLAGS, d);
        chk("capture flag cleared", 16'h0000, 16'(d[FLG_CAPTURE]));
        // a compare high read holds off matches until the low byte is read
        wr(ADDR_TIMER_CTRL, 8'h08);
        wr(ADDR_IRQ_MASK, 8'h02);
        aim(16'd60);
        rd(ADDR_COMPARE_HIGH, d);
        repeat (100) @(posedge i_ref_clk);
        rd(ADDR_TIMER_FLAGS, d);
        chk("compare held off", 16'h0000, 16'(d[FLG_COMPARE]));
        chk("irq held off", 16'h0000, 16'(o_irq));
        rd(ADDR_COMPARE_LOW, d);
        aim(16'd60);
        poll(ADDR_TIMER_FLAGS, FLG_COMPARE);
        settle();
        chk("irq on compare", 16'h0001, 16'(o_irq));
        rd(ADDR_COMPARE_LOW, d);
        rd(ADDR_TIMER_FLAGS, d);
        chk("compare flag cleared", 16'h0000, 16'(d[FLG_COMPARE]));
        // sticky status clears by writing one
        wr(ADDR_IRQ_STATUS, 8'h02);
        settle();
        chk("irq cleared", 16'h0000, 16'(o_irq));
        rd(ADDR_IRQ_STATUS, d);
        chk("status compare bit", 16'h0000, 16'(d[IRQ_COMPARE]));
        // keeps dropped in a write of their own before the channel moves
        wr(ADDR_CHANNEL_SEL, 8'h40);
        wr(ADDR_CHANNEL_SEL, 8'h00);
        wr(ADDR_CHANNEL_SEL, 8'h01);
        settle();
        chk("channel_select", 16'h0001, 16'(o_analog.channel_select));
        rd(ADDR_IRQ_STATUS, d);
        chk("status chan bit clean", 16'h0000, 16'(d[IRQ_CHAN_ERR]));
        // moving the channel with a keep still on is flagged
        wr(ADDR_CHANNEL_SEL, 8'h81);
        wr(ADDR_CHANNEL_SEL, 8'h82);
        rd(ADDR_IRQ_STATUS, d);
        chk("status chan bit", 16'h0001, 16'(d[IRQ_CHAN_ERR]));
        conclude();
    end
endmodule // slope_adc_timer_control_test
`default_nettype wire
